// ==== stack_shift_pkg.sv ====
// package for the stack and shift execution unit
// assumes a 20-bit register file of 16 entries and a word-wide data memory
package stack_shift_pkg;
  localparam int REG_W = 20;
  localparam int WORD_W = 16;
  localparam int NREG = 16;
  localparam int IDX_W = 4;
  localparam int CNT_W = 5;
  localparam int MSB_A = 19;
  localparam int MSB_W = 15;
  localparam int MSB_B = 7;
  localparam logic [IDX_W-1:0] SR_IDX = 4'h2;
  localparam logic [IDX_W-1:0] SP_IDX = 4'h1;
  localparam logic [REG_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [REG_W-1:0] STEP_ADDR = 20'h00004;
  localparam logic [REG_W-1:0] OVF_LO_A = 20'h40000;
  localparam logic [REG_W-1:0] OVF_HI_A = 20'hC0000;
  localparam logic [REG_W-1:0] OVF_LO_W = 20'h04000;
  localparam logic [REG_W-1:0] OVF_HI_W = 20'h0C000;
  localparam logic [REG_W-1:0] OVF_LO_B = 20'h00040;
  localparam logic [REG_W-1:0] OVF_HI_B = 20'h000C0;
  localparam logic [REG_W-1:0] MASK_A = 20'hFFFFF;
  localparam logic [REG_W-1:0] MASK_W = 20'h0FFFF;
  localparam logic [REG_W-1:0] MASK_B = 20'h000FF;
  // status register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 8;
  localparam logic [2:0] SHIFT_MAX = 3'h4;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h10;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_ADDR} size_t;
  typedef enum logic [2:0] {OP_PUSH_MULTIPLE, OP_POP_MULTIPLE, OP_PUSH_SINGLE_EXT, OP_POP_SINGLE_EXT, OP_SLAM, OP_SLAX, OP_ROTATE_LEFT_CARRY_EXT, OP_SRAM} op_t;
endpackage

// ==== shift_unit.sv ====
// single-cycle shift datapath with flag generation
// assumes the caller has checked the shift count range
`timescale 1ns/10ps
module shift_unit
  import stack_shift_pkg::*;
(
  input wire logic [2:0] i_op,
  input wire logic [1:0] i_size,
  input wire logic [2:0] i_count,
  input wire logic [REG_W-1:0] i_val,
  input wire logic i_carry,
  output logic [REG_W-1:0] o_res,
  output logic o_c,
  output logic o_z,
  output logic o_n,
  output logic o_v
);
  // --------------------------------
  // width helpers
  // --------------------------------
  function automatic logic [REG_W-1:0] size_mask(input logic [1:0] s);
    unique case (s)
      SZ_BYTE: size_mask = MASK_B;
      SZ_WORD: size_mask = MASK_W;
      default: size_mask = MASK_A;
    endcase
  endfunction
  function automatic int size_msb(input logic [1:0] s);
    unique case (s)
      SZ_BYTE: size_msb = MSB_B;
      SZ_WORD: size_msb = MSB_W;
      default: size_msb = MSB_A;
    endcase
  endfunction
  // --------------------------------
  // shift and flags
  // --------------------------------
  always_comb begin
    logic [REG_W-1:0] m;
    logic [REG_W-1:0] v;
    logic [REG_W-1:0] r;
    logic c;
    int msb;
    m = size_mask(i_size);
    msb = size_msb(i_size);
    v = i_val & m;
    r = v;
    c = i_carry;
    o_v = 1'b0;
    unique case (op_t'(i_op))
      OP_SLAM: begin
        for (int k = 0; k < 4; k++) begin
          if (k < int'(i_count)) begin
            c = r[msb];
            r = (r << 1) & m;
          end
        end
      end
      OP_SLAX, OP_ROTATE_LEFT_CARRY_EXT: begin
        c = v[msb];
        r = ((v << 1) | ((op_t'(i_op) == OP_ROTATE_LEFT_CARRY_EXT) ? {{(REG_W-1){1'b0}}, i_carry} : '0)) & m;
        unique case (i_size)
          SZ_BYTE: o_v = (v >= OVF_LO_B) && (v < OVF_HI_B);
          SZ_WORD: o_v = (v >= OVF_LO_W) && (v < OVF_HI_W);
          default: o_v = (v >= OVF_LO_A) && (v < OVF_HI_A);
        endcase
      end
      OP_SRAM: begin
        for (int k = 0; k < 4; k++) begin
          if (k < int'(i_count)) begin
            c = r[0];
            r = ((r >> 1) | (r & (MASK_A ^ (MASK_A >> 1)) >> (REG_W-1-msb))) & m;
          end
        end
      end
      default: r = v;
    endcase
    o_res = r;
    o_c = c;
    o_z = (r == '0);
    o_n = r[msb];
  end
endmodule // shift_unit

// ==== stack_shift_core.sv ====
// execution unit for multi-register and single push/pop and extended shifts
// assumes a word-wide data memory with one-cycle acknowledge; single operands
// arrive already fetched by the address generator of the core
//
// What this block does
// - address-word multi pop fills ascending from dst-n+1, sp rises by 4n
// - word multi pop raises sp by 2n and clears bits 19:16 of each register
// - multi pop keeps flags unless the status register itself is restored
// - multi push stores from named register downward, count 1 to 16
// - address-word multi push: sp minus 4 each, upper part at higher address
// - word multi push: sp minus 2 each, registers themselves untouched
// - single pop copies top item, sp plus 4 address-word, else plus 2
// - single pop accepts register, indexed, symbolic, absolute destinations, 20-bit
// - single push lowers sp first, then writes source at new top
// - single push accepts all seven source addressing modes
// - multi push and multi shifts need no extension word
// - multi left shift by 1 to 4, zero fill
// - multi left shift carry from msb, msb-1, msb-2, msb-3
// - word multi left shift clears 19:16; v cleared; z on zero
// - multi left shift negative from bit 19, bit 15 or bit 7, by operand size
// - single left shift: msb to carry, zero into lsb
// - single left shifts set v for operand in overflow window
// - rotate left through carry puts old carry into lsb
// - single left shifts set z on zero and n from top bit
// - multi right shift keeps sign, last bit out goes to carry
// - word multi right shift clears bits 19:16
// - pushes, shifts and pops other than into the status register leave oscillator, core-off and irq enable bits
// - address-word multi pop restores 20 bits from two stack words
`timescale 1ns/10ps
module stack_shift_core
  import stack_shift_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic [1:0] i_size,
  input wire logic [CNT_W-1:0] i_count,
  input wire logic [IDX_W-1:0] i_dst,
  input wire logic [REG_W-1:0] i_operand,
  input wire logic [REG_W-1:0] i_mem_rdata,
  input wire logic i_mem_ack,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [REG_W-1:0] o_mem_addr,
  output logic [WORD_W-1:0] o_mem_wdata,
  output logic [REG_W-1:0] o_result,
  output logic o_result_valid,
  output logic [REG_W-1:0] o_reg_dbg,
  input wire logic [IDX_W-1:0] i_dbg_idx
);
  // --------------------------------
  // state and storage
  // --------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_POP, ST_DONE} state_t;
  state_t state, next_state;
  logic [REG_W-1:0] regs [NREG];
  logic [REG_W-1:0] next_regs [NREG];
  logic [IDX_W-1:0] idx, next_idx;
  logic [CNT_W-1:0] left, next_left;
  logic half, next_half;
  logic [2:0] op, next_op;
  logic [1:0] sz, next_sz;
  logic [REG_W-1:0] hold, next_hold;
  logic busy, next_busy, done, next_done, err, next_err;
  logic req, next_req, we, next_we;
  logic [REG_W-1:0] addr, next_addr;
  logic [WORD_W-1:0] wdata, next_wdata;
  logic [REG_W-1:0] result, next_result;
  logic rvalid, next_rvalid;
  logic [REG_W-1:0] dbg, next_dbg;
  logic [REG_W-1:0] sh_res;
  logic sh_c, sh_z, sh_n, sh_v;
  logic is_shift, bad_count;
  logic [IDX_W-1:0] op_start_idx;

  // --------------------------------
  // shift datapath
  // --------------------------------
  shift_unit u_shift (
    .i_op(i_op),
    .i_size(i_size),
    .i_count(i_count[2:0]),
    .i_val((i_op == OP_SLAX || i_op == OP_ROTATE_LEFT_CARRY_EXT) ? i_operand : regs[i_dst]),
    .i_carry(regs[SR_IDX][FLAG_C]),
    .o_res(sh_res),
    .o_c(sh_c),
    .o_z(sh_z),
    .o_n(sh_n),
    .o_v(sh_v)
  );

  assign is_shift = (i_op == OP_SLAM) || (i_op == OP_SRAM);
  // count checks; multi pushes decode without a prefix word, so count is in i_count
  assign bad_count = ((i_op == OP_PUSH_MULTIPLE || i_op == OP_POP_MULTIPLE) &&
                      (i_count == '0 || i_count > CNT_MAX)) ||
                     (is_shift && (i_count == '0 || i_count > {2'h0, SHIFT_MAX}));

  function automatic logic [REG_W-1:0] step_of(input logic [1:0] s);
    step_of = (s == SZ_ADDR) ? STEP_ADDR : STEP_WORD;
  endfunction

  // count of registers moved by the running multi push; start index minus final index plus one
  function automatic logic [CNT_W-1:0] left_init(input logic [IDX_W-1:0] i);
    left_init = {1'b0, op_start_idx - i} + 5'h01;
  endfunction

  // --------------------------------
  // next state
  // --------------------------------
  always_comb begin
    next_state = state;
    next_regs = regs;
    next_idx = idx;
    next_left = left;
    next_half = half;
    next_op = op;
    next_sz = sz;
    next_hold = hold;
    next_busy = busy;
    next_done = 1'b0;
    next_err = 1'b0;
    next_req = req;
    next_we = we;
    next_addr = addr;
    next_wdata = wdata;
    next_result = result;
    next_rvalid = 1'b0;
    next_dbg = regs[i_dbg_idx];
    unique case (state)
      ST_IDLE: begin
        if (i_start && bad_count) begin
          next_err = 1'b1;
          next_done = 1'b1;
        end else if (i_start) begin
          next_op = i_op;
          next_sz = i_size;
          next_left = i_count;
          next_half = 1'b0;
          next_busy = 1'b1;
          unique case (op_t'(i_op))
            OP_PUSH_MULTIPLE: begin
              next_idx = i_dst;
              next_addr = regs[SP_IDX] - STEP_WORD;
              next_wdata = (i_size == SZ_ADDR) ? {12'h000, regs[i_dst][MSB_A:WORD_W]}
                                               : regs[i_dst][WORD_W-1:0];
              next_half = (i_size == SZ_ADDR);
              next_we = 1'b1;
              next_req = 1'b1;
              next_state = ST_PUSH;
            end
            OP_PUSH_SINGLE_EXT: begin
              next_regs[SP_IDX] = regs[SP_IDX] - step_of(i_size);
              next_addr = regs[SP_IDX] - STEP_WORD;
              next_wdata = (i_size == SZ_ADDR) ? {12'h000, i_operand[MSB_A:WORD_W]} : i_operand[WORD_W-1:0];
              next_half = (i_size == SZ_ADDR);
              next_hold = i_operand;
              next_left = 5'h01;
              next_we = 1'b1;
              next_req = 1'b1;
              next_state = ST_PUSH;
            end
            OP_POP_MULTIPLE, OP_POP_SINGLE_EXT: begin
              next_idx = (i_op == OP_POP_MULTIPLE) ? i_dst - i_count[IDX_W-1:0] + 4'h1 : i_dst;
              next_left = (i_op == OP_POP_MULTIPLE) ? i_count : 5'h01;
              next_addr = regs[SP_IDX];
              next_we = 1'b0;
              next_req = 1'b1;
              next_state = ST_POP;
            end
            default: begin
              // shifts complete in one cycle, mode bits untouched
              next_regs[i_dst] = sh_res;
              if (is_shift || i_op == OP_SLAX || i_op == OP_ROTATE_LEFT_CARRY_EXT) begin
                next_result = sh_res;
                next_regs[SR_IDX][FLAG_C] = sh_c;
                next_regs[SR_IDX][FLAG_Z] = sh_z;
                next_regs[SR_IDX][FLAG_N] = sh_n;
                next_regs[SR_IDX][FLAG_V] = sh_v;
              end
              if (i_op == OP_SLAX || i_op == OP_ROTATE_LEFT_CARRY_EXT) begin
                next_regs[i_dst] = regs[i_dst]; // memory operands are written back by caller
                next_rvalid = 1'b1;
              end
              next_busy = 1'b0;
              next_done = 1'b1;
            end
          endcase
        end
      end
      ST_PUSH: begin
        if (i_mem_ack) begin
          next_addr = addr - STEP_WORD;
          if (half) begin
            // upper part sits at the higher address, lower word follows below
            next_wdata = (op == OP_PUSH_SINGLE_EXT) ? hold[WORD_W-1:0] : regs[idx][WORD_W-1:0];
            next_half = 1'b0;
          end else if (left == 5'h01 || op == OP_PUSH_SINGLE_EXT) begin
            if (op == OP_PUSH_MULTIPLE) begin
              next_regs[SP_IDX] = regs[SP_IDX] - (step_of(sz) * REG_W'(left_init(idx)));
            end
            next_req = 1'b0;
            next_we = 1'b0;
            next_state = ST_DONE;
          end else begin
            next_idx = idx - 4'h1;
            next_left = left - 5'h01;
            next_wdata = (sz == SZ_ADDR) ? {12'h000, regs[idx - 4'h1][MSB_A:WORD_W]} : regs[idx - 4'h1][WORD_W-1:0];
            next_half = (sz == SZ_ADDR);
          end
        end
      end
      ST_POP: begin
        if (i_mem_ack) begin
          next_addr = addr + STEP_WORD;
          if (sz == SZ_ADDR && !half) begin
            next_hold = {4'h0, i_mem_rdata[WORD_W-1:0]};
            next_half = 1'b1;
          end else begin
            if (sz == SZ_ADDR) begin
              next_result = {i_mem_rdata[3:0], hold[WORD_W-1:0]};
            end else begin
              next_result = {4'h0, i_mem_rdata[WORD_W-1:0]} & ((sz == SZ_BYTE) ? MASK_B : MASK_W);
            end
            if (op == OP_POP_MULTIPLE) begin
              next_regs[idx] = next_result;
            end else begin
              next_rvalid = 1'b1;
            end
            next_half = 1'b0;
            if (left == 5'h01) begin
              next_regs[SP_IDX] = next_addr;
              if (op == OP_POP_SINGLE_EXT && sz != SZ_ADDR) begin
                next_regs[SP_IDX] = regs[SP_IDX] + STEP_WORD;
              end
              next_req = 1'b0;
              next_state = ST_DONE;
            end else begin
              next_idx = idx + 4'h1;
              next_left = left - 5'h01;
            end
          end
        end
      end
      ST_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // named register of the running operation, kept for the final stack pointer step
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_start_idx <= '0;
    end else if (i_ce && state == ST_IDLE && i_start) begin
      op_start_idx <= i_dst;
    end
  end

  // --------------------------------
  // registers
  // --------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      for (int k = 0; k < NREG; k++) begin
        regs[k] <= '0;
      end
      idx <= '0;
      left <= '0;
      half <= 1'b0;
      op <= '0;
      sz <= '0;
      hold <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      req <= 1'b0;
      we <= 1'b0;
      addr <= '0;
      wdata <= '0;
      result <= '0;
      rvalid <= 1'b0;
      dbg <= '0;
    end else if (i_ce) begin
      state <= next_state;
      regs <= next_regs;
      idx <= next_idx;
      left <= next_left;
      half <= next_half;
      op <= next_op;
      sz <= next_sz;
      hold <= next_hold;
      busy <= next_busy;
      done <= next_done;
      err <= next_err;
      req <= next_req;
      we <= next_we;
      addr <= next_addr;
      wdata <= next_wdata;
      result <= next_result;
      rvalid <= next_rvalid;
      dbg <= next_dbg;
    end
  end

  assign o_busy = busy;
  assign o_done = done;
  assign o_error = err;
  assign o_mem_req = req;
  assign o_mem_we = we;
  assign o_mem_addr = addr;
  assign o_mem_wdata = wdata;
  assign o_result = result;
  assign o_result_valid = rvalid;
  assign o_reg_dbg = dbg;

  // --------------------------------
  // checks
  // --------------------------------
  property p_bad_count;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_IDLE && i_start && bad_count) |=> (err && done);
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count not refused");

  property p_push_dir;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_PUSH && i_mem_ack) |=> (addr == $past(addr) - STEP_WORD);
  endproperty
  a_push_dir: assert property (p_push_dir) else $error("push address not descending");

  property p_pop_dir;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_POP && i_mem_ack) |=> (addr == $past(addr) + STEP_WORD);
  endproperty
  a_pop_dir: assert property (p_pop_dir) else $error("pop address not ascending");

  property p_done_pulse;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_DONE) |=> (done && !busy);
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done missing");

  property p_push_multiple_keep;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_PUSH && half && op == OP_PUSH_MULTIPLE) |=> (regs[idx] == $past(regs[idx]));
  endproperty
  a_push_multiple_keep: assert property (p_push_multiple_keep) else $error("pushed register changed");

  property p_push_single_ext_sp;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_IDLE && i_start && !bad_count && i_op == OP_PUSH_SINGLE_EXT)
        |=> (regs[SP_IDX] == $past(regs[SP_IDX]) - step_of($past(i_size)));
  endproperty
  a_push_single_ext_sp: assert property (p_push_single_ext_sp) else $error("single push sp wrong");

  property p_slam_z;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_IDLE && i_start && !bad_count && i_op == OP_SLAM)
        |=> (regs[SR_IDX][FLAG_Z] == (result == '0));
  endproperty
  a_slam_z: assert property (p_slam_z) else $error("zero flag wrong after shift");

  property p_word_clear;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && state == ST_POP && i_mem_ack && sz == SZ_WORD && op == OP_POP_MULTIPLE)
        |=> (regs[$past(idx)][MSB_A:WORD_W] == 4'h0);
  endproperty
  a_word_clear: assert property (p_word_clear) else $error("upper bits not cleared");

  // address-word push: the lower word must follow its upper word, still as a write
  sequence s_upper_acked;
    i_ce && state == ST_PUSH && half && i_mem_ack;
  endsequence
  sequence s_lower_out;
    req && we && !half;
  endsequence
  property p_upper_first;
    @(posedge i_clk) disable iff (i_rst)
      s_upper_acked |=> s_lower_out;
  endproperty
  a_upper_first: assert property (p_upper_first) else $error("lower word not after upper");
endmodule // stack_shift_core

// ==== stack_mem_model.sv ====
// word-wide stack memory standing behind the execution core
// assumes each request is held until it is acknowledged
`timescale 1ns/10ps
module stack_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic [19:0] o_rdata
);
  logic [15:0] mem [logic [19:0]];
  int unsigned wait_left = 0;

  initial begin
    o_ack = 1'b0;
    o_rdata = 20'h5A5A5;
  end

  // one ack pulse after 0 to 2 wait cycles; an idle read bus toggles so stale data never matches
  always @(posedge i_clk) begin
    if (o_ack || !i_req) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (wait_left != 0) begin
      wait_left <= wait_left - 1;
      o_rdata <= ~o_rdata;
    end else begin
      o_ack <= 1'b1;
      wait_left <= $urandom % 3;
      if (i_we) begin
        mem[i_addr] = i_wdata;
      end else begin
        o_rdata <= {4'hF, mem[i_addr]}; // junk upper nibble must be ignored
      end
    end
  end
endmodule // stack_mem_model

// ==== stack_multi_and_shift_execution_bench.sv ====
// self-checking bench for the stack and shift execution core
// assumes the stack memory model and the core's package
`timescale 1ns/10ps
module stack_multi_and_shift_execution_bench;
  import stack_shift_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic ce = 1'b1;
  logic [2:0] i_op = 3'h0;
  logic [1:0] i_size = 2'h0;
  logic [CNT_W-1:0] i_count = 5'h01;
  logic [IDX_W-1:0] i_dst = 4'h0;
  logic [IDX_W-1:0] i_dbg_idx = 4'h0;
  logic [REG_W-1:0] i_operand = 20'h00000;
  logic [REG_W-1:0] rdata, addr, result, reg_dbg, sp, sr;
  logic ack, done, err, req, we, rvalid;
  logic [WORD_W-1:0] wdata;
  logic [REG_W-1:0] rm [NREG];
  logic [35:0] wr_q [$];
  logic [REG_W-1:0] res_q [$];
  int fails = 0;
  int samples_checked = 0;

  always #5 i_clk = ~i_clk;

  stack_shift_core i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_start(i_start), .i_op(i_op),
    .i_size(i_size), .i_count(i_count), .i_dst(i_dst), .i_operand(i_operand), .i_mem_rdata(rdata),
    .i_mem_ack(ack), .o_busy(), .o_done(done), .o_error(err), .o_mem_req(req), .o_mem_we(we),
    .o_mem_addr(addr), .o_mem_wdata(wdata), .o_result(result), .o_result_valid(rvalid),
    .o_reg_dbg(reg_dbg), .i_dbg_idx(i_dbg_idx));

  stack_mem_model stack_mem (.i_clk(i_clk), .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata),
    .o_ack(ack), .o_rdata(rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // oldest note is taken off its queue as each write or result appears
  always @(posedge i_clk) begin
    if ((req & we & ack) !== 1'b0) begin
      chk({addr, wdata}, (wr_q.size() != 0) ? wr_q.pop_front() : 36'hFFFFFFFFF);
    end
    // a result with no note, or an unknown strobe, counts as a mismatch
    if (rvalid !== 1'b0) begin
      chk({rvalid, result}, (res_q.size() != 0) ? {1'b1, res_q.pop_front()} : 21'h0);
    end
  end

  // start one operation and wait, bounded, for its done pulse
  task automatic run(input logic [2:0] op, input logic [1:0] sz, input int n, input int d,
                     input logic [REG_W-1:0] opd, input logic exp_err);
    int t;
    t = 0;
    @(posedge i_clk);
    i_op <= op;
    i_size <= sz;
    i_count <= 5'(n);
    i_dst <= 4'(d);
    i_operand <= opd;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    while (done !== 1'b1 && t < 300) begin
      @(posedge i_clk);
      #1;
      t++;
    end
    chk({34'h0, done, err}, {34'h0, 1'b1, exp_err});
  endtask

  task automatic chk_reg(input int idx, input logic [REG_W-1:0] exp);
    @(posedge i_clk);
    i_dbg_idx <= 4'(idx);
    repeat (2) @(posedge i_clk);
    #1;
    chk(reg_dbg, exp);
  endtask

  task automatic fill(input int words);
    for (int i = 0; i < words; i++) begin
      stack_mem.mem[sp + 20'(2 * i)] = 16'($urandom);
    end
  endtask

  // upper part goes to the higher address, stack pointer lowered first
  task automatic note_push(input logic [1:0] sz, input logic [REG_W-1:0] r);
    if (sz == SZ_ADDR) begin
      wr_q.push_back({sp - 20'h2, 12'h000, r[19:16]});
      wr_q.push_back({sp - 20'h4, r[15:0]});
      sp = sp - 20'h4;
    end else begin
      wr_q.push_back({sp - 20'h2, r[15:0]});
      sp = sp - 20'h2;
    end
  endtask

  task automatic take_pop(input logic [1:0] sz, output logic [REG_W-1:0] r);
    r = {4'h0, stack_mem.mem[sp]};
    if (sz == SZ_ADDR) begin
      r[19:16] = stack_mem.mem[sp + 20'h2][3:0];
      sp = sp + 20'h4;
    end else begin
      sp = sp + 20'h2;
    end
    if (sz == SZ_BYTE) begin
      r = r & MASK_B;
    end
  endtask

  // reference shift: returns {v, n, z, c, result}
  function automatic logic [23:0] model(input logic [2:0] op, input logic [1:0] sz, input int n,
                                        input logic [REG_W-1:0] v, input logic cin);
    int w;
    logic [REG_W-1:0] m, r;
    logic c, ov;
    w = (sz == SZ_ADDR) ? 20 : (sz == SZ_WORD) ? 16 : 8;
    m = (sz == SZ_ADDR) ? MASK_A : (sz == SZ_WORD) ? MASK_W : MASK_B;
    r = v & m;
    c = 1'b0;
    ov = (sz == SZ_ADDR) ? (r >= OVF_LO_A && r < OVF_HI_A) : (sz == SZ_WORD) ? (r >= OVF_LO_W && r < OVF_HI_W)
         : (r >= OVF_LO_B && r < OVF_HI_B);
    for (int i = 0; i < n; i++) begin
      c = (op == OP_SRAM) ? r[0] : r[w-1];
      r = (op == OP_SRAM) ? ((r >> 1) | (r & (20'h1 << (w - 1)))) : (((r << 1) | 20'(op == OP_ROTATE_LEFT_CARRY_EXT && cin)) & m);
    end
    if (op == OP_SLAM || op == OP_SRAM) begin
      ov = 1'b0;
    end
    return {ov, r[w-1], r == 20'h0, c, r};
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [23:0] e;
    logic [REG_W-1:0] x, lo, hi;
    logic [2:0] op;
    logic [1:0] sz;
    int n, d;
    x = 20'($urandom(32103));
    sp = 20'h0;
    foreach (rm[i]) rm[i] = 20'h0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    // status register restored by a word pop, mode bits set
    stack_mem.mem[20'h0] = 16'h0038;
    take_pop(SZ_WORD, sr);
    run(OP_POP_MULTIPLE, SZ_WORD, 1, 2, 20'h0, 1'b0);
    chk_reg(2, sr);
    // address-word pop of three, then word pop of two
    fill(6);
    for (int i = 4; i <= 6; i++) take_pop(SZ_ADDR, rm[i]);
    run(OP_POP_MULTIPLE, SZ_ADDR, 3, 6, 20'h0, 1'b0);
    for (int i = 4; i <= 6; i++) chk_reg(i, rm[i]);
    fill(2);
    for (int i = 7; i <= 8; i++) take_pop(SZ_WORD, rm[i]);
    run(OP_POP_MULTIPLE, SZ_WORD, 2, 8, 20'h0, 1'b0);
    for (int i = 7; i <= 8; i++) chk_reg(i, rm[i]);
    chk_reg(1, sp);
    chk_reg(2, sr);
    $display("test multi pop done");
    // multi pushes: registers must survive
    for (int i = 0; i < 2; i++) note_push(SZ_ADDR, rm[5 - i]);
    run(OP_PUSH_MULTIPLE, SZ_ADDR, 2, 5, 20'h0, 1'b0);
    for (int i = 0; i < 3; i++) note_push(SZ_WORD, rm[8 - i]);
    run(OP_PUSH_MULTIPLE, SZ_WORD, 3, 8, 20'h0, 1'b0);
    chk_reg(1, sp);
    for (int i = 4; i <= 8; i++) chk_reg(i, rm[i]);
    $display("test multi push done");
    // single pushes and pops, wrapping below address zero
    x = 20'($urandom);
    note_push(SZ_ADDR, x);
    run(OP_PUSH_SINGLE_EXT, SZ_ADDR, 1, 3, x, 1'b0);
    note_push(SZ_WORD, x & MASK_W);
    run(OP_PUSH_SINGLE_EXT, SZ_WORD, 1, 3, x & MASK_W, 1'b0);
    chk_reg(1, sp);
    for (int k = 0; k < 3; k++) begin
      sz = (k == 0) ? SZ_WORD : (k == 1) ? SZ_ADDR : SZ_BYTE;
      take_pop(sz, lo);
      res_q.push_back(lo);
      run(OP_POP_SINGLE_EXT, sz, 1, 3, 20'h0, 1'b0);
      chk_reg(1, sp);
    end
    chk_reg(2, sr);
    $display("test single push pop done");
    // shifts: every count, word and address-word multi, all sizes single, overflow window edges
    for (int k = 0; k < 24; k++) begin
      op = (k % 4 == 0) ? OP_SLAM : (k % 4 == 1) ? OP_SRAM : (k % 4 == 2) ? OP_SLAX : OP_ROTATE_LEFT_CARRY_EXT;
      if (op == OP_SLAM || op == OP_SRAM) begin
        sz = (k % 8 < 4) ? SZ_ADDR : SZ_WORD;
        n = 1 + (k / 4) % 4;
        d = 4 + k % 5;
        e = model(op, sz, n, rm[d], sr[0]);
        rm[d] = e[19:0];
        run(op, sz, n, d, 20'h0, 1'b0);
        chk_reg(d, rm[d]);
      end else begin
        sz = 2'(k % 3);
        lo = (sz == SZ_ADDR) ? OVF_LO_A : (sz == SZ_WORD) ? OVF_LO_W : OVF_LO_B;
        hi = (sz == SZ_ADDR) ? OVF_HI_A : (sz == SZ_WORD) ? OVF_HI_W : OVF_HI_B;
        x = (k < 8) ? ((k % 2) ? hi - 20'h1 : lo - 20'h1) : (k < 16) ? ((k % 2) ? hi : lo) : 20'($urandom);
        x = x & ((sz == SZ_ADDR) ? MASK_A : (sz == SZ_WORD) ? MASK_W : MASK_B);
        e = model(op, sz, 1, x, sr[0]);
        res_q.push_back(e[19:0]);
        run(op, sz, 1, 3, x, 1'b0);
      end
      sr[2:0] = e[22:20];
      sr[8] = e[23];
      chk_reg(2, sr);
    end
    $display("test shifts done");
    // out-of-range counts are refused and change nothing
    for (int k = 0; k < 4; k++) begin
      op = (k == 0) ? OP_POP_MULTIPLE : (k == 1) ? OP_PUSH_MULTIPLE : (k == 2) ? OP_SLAM : OP_SRAM;
      n = (k == 0 || k == 3) ? 0 : (k == 1) ? 17 : 5;
      run(op, SZ_WORD, n, 6, 20'h0, 1'b1);
    end
    // a frozen core must ignore a start that stands while the enable is low
    @(posedge i_clk);
    ce <= 1'b0;
    i_op <= OP_SLAM;
    i_count <= 5'h01;
    i_dst <= 4'h6;
    i_start <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_start <= 1'b0;
    ce <= 1'b1;
    chk_reg(1, sp);
    chk_reg(6, rm[6]);
    chk_reg(2, sr);
    chk(36'(wr_q.size() + res_q.size()), 36'h0);
    $display("test refusals done");
    tally_and_finish();
  end

  // watchdog sized well above the expected run of a few hundred cycles
  initial begin
    #200000;
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // stack_multi_and_shift_execution_bench
